// *** rtl/nibble_skip_table_xor_exec.sv ***
// Execution unit for nibble exchange, zero skips, table reads and exclusive-or
// Behaviour
// RQ1 - Nibble exchange to memory writes byte back with nibbles swapped, flags kept
// RQ2 - Nibble exchange to work register loads swapped byte, memory and flags kept
// RQ3 - Skip on zero byte discards next instruction when byte is zero
// RQ4 - A taken skip inserts one dummy cycle, two cycles in all
// RQ5 - An untaken skip continues with the next instruction normally
// RQ6 - Copy and skip loads byte into work register, skips if zero
// RQ7 - Bit test skips the next instruction when the selected bit is zero
// RQ8 - Specific page table read uses high and low pointers, low to memory
// RQ9 - Current page table read uses low pointer within current program page
// RQ10 - Last page table read uses low pointer within the final page
// RQ11 - Register exclusive-or stores result in work register, zero flag only
// RQ12 - Exclusive-or to memory writes result to the byte, zero flag only
// RQ13 - Immediate exclusive-or stores result in work register, zero flag only
// RQ14 - Zero flag set when the eight bit result is zero, else cleared
// RQ15 - Current page is upper counter bits; last page sets them all to one
`timescale 1ns/10ps

module nibble_skip_table_xor_exec
  import exec_pkg::*;
#(
  parameter int PC_WIDTH   = exec_pkg::PC_W,
  parameter int WORD_WIDTH = exec_pkg::WORD_W
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_rstn,
  input  wire logic                         i_valid,
  input  wire exec_pkg::op_t                i_op,
  input  wire logic [exec_pkg::DATA_W-1:0]  i_addr,
  input  wire logic [exec_pkg::BIT_W-1:0]   i_bit,
  input  wire logic [exec_pkg::DATA_W-1:0]  i_imm,
  input  wire logic [exec_pkg::DATA_W-1:0]  i_mem_rdata,
  input  wire logic [PC_WIDTH-1:0]          i_pc,
  input  wire logic [exec_pkg::PTR_W-1:0]   i_table_low_pointer,
  input  wire logic [exec_pkg::PTR_W-1:0]   i_table_high_pointer,
  input  wire logic [WORD_WIDTH-1:0]        i_prog_rdata,
  output logic                              o_ready,
  output logic                              o_skip,
  output logic                              o_mem_we,
  output logic [exec_pkg::DATA_W-1:0]       o_mem_addr,
  output logic [exec_pkg::DATA_W-1:0]       o_mem_wdata,
  output logic                              o_prog_re,
  output logic [PC_WIDTH-1:0]               o_prog_addr,
  output logic [exec_pkg::DATA_W-1:0]       o_work_register,
  output logic                              o_zero_flag,
  output logic [WORD_WIDTH-DATA_W-1:0]      o_table_high_byte_latch
);

  import exec_pkg::*;

  localparam int HI_W = WORD_WIDTH - DATA_W;
  localparam int PG_W = PC_WIDTH - PTR_W;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  state_t state;
  state_t next_state;

  logic [DATA_W-1:0] table_addr_hold;
  logic [DATA_W-1:0] mem_target;

  wire accept = i_valid && (state == ST_IDLE);

  wire is_swap_mem  = (i_op == OP_SWAP_MEM);
  wire is_swap_work = (i_op == OP_SWAP_WORK);
  wire is_skip_zero = (i_op == OP_SKIP_ZERO);
  wire is_copy_skip = (i_op == OP_COPY_SKIP);
  wire is_skip_bit  = (i_op == OP_SKIP_BIT);
  wire is_tbl_spec  = (i_op == OP_TBL_SPEC);
  wire is_tbl_cur   = (i_op == OP_TBL_CUR);
  wire is_tbl_last  = (i_op == OP_TBL_LAST);
  wire is_xor_work  = (i_op == OP_XOR_WORK);
  wire is_xor_mem   = (i_op == OP_XOR_MEM);
  wire is_xor_imm   = (i_op == OP_XOR_IMM);

  wire is_skip_op  = is_skip_zero || is_copy_skip || is_skip_bit;
  wire is_table_op = is_tbl_spec || is_tbl_cur || is_tbl_last;
  wire is_xor_op   = is_xor_work || is_xor_mem || is_xor_imm;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath

  wire [DATA_W-1:0] swapped =
    {i_mem_rdata[NIB_W-1:0], i_mem_rdata[DATA_W-1:NIB_W]};        // see RQ1 RQ2

  wire byte_zero = (i_mem_rdata == ZERO_BYTE);                      // see RQ3 RQ6
  wire sel_bit   = i_mem_rdata[i_bit];                              // see RQ7

  wire skip_cond = (is_skip_zero || is_copy_skip) ? byte_zero       // see RQ3 RQ6
                 : is_skip_bit ? !sel_bit                           // see RQ7
                 : 1'b0;

  wire skip_taken = accept && is_skip_op && skip_cond;              // see RQ4 RQ5

  wire [DATA_W-1:0] xor_operand = is_xor_imm ? i_imm : i_mem_rdata; // see RQ13
  wire [DATA_W-1:0] xor_res     = o_work_register ^ xor_operand;    // see RQ11 RQ12
  wire              xor_zero    = (xor_res == ZERO_BYTE);           // see RQ14

  // Pointer pair is wider than the counter; upper pointer bits fall off
  wire [2*PTR_W-1:0]   pair_addr = {i_table_high_pointer, i_table_low_pointer};
  wire [PC_WIDTH-1:0]  spec_addr = pair_addr[PC_WIDTH-1:0];           // see RQ8
  wire [PC_WIDTH-1:0]  cur_addr  =
    {i_pc[PC_WIDTH-1:PTR_W], i_table_low_pointer};                   // see RQ9 RQ15
  wire [PC_WIDTH-1:0]  last_addr =
    {{PG_W{1'b1}}, i_table_low_pointer};                             // see RQ10 RQ15

  wire [PC_WIDTH-1:0] table_addr = is_tbl_spec ? spec_addr
                                 : is_tbl_cur  ? cur_addr
                                 : last_addr;

  wire [DATA_W-1:0] prog_lo = i_prog_rdata[DATA_W-1:0];
  wire [HI_W-1:0]   prog_hi = i_prog_rdata[WORD_WIDTH-1:DATA_W];

  // Only a memory-writing op, or a table read, produces a data write
  wire mem_write_now = accept && (is_swap_mem || is_xor_mem);

  wire [DATA_W-1:0] mem_wdata_now = is_swap_mem ? swapped : xor_res;

  wire work_load = accept && (is_swap_work || is_copy_skip ||
                              is_xor_work || is_xor_imm);

  wire [DATA_W-1:0] work_value = is_swap_work ? swapped            // see RQ2
                               : is_copy_skip ? i_mem_rdata        // see RQ6
                               : xor_res;                          // see RQ11 RQ13

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (skip_taken) begin
          next_state = ST_SKIP;                                     // see RQ4
        end else if (accept && is_table_op) begin
          next_state = ST_TBL_REQ;
        end
      end
      ST_SKIP:     next_state = ST_IDLE;
      ST_TBL_REQ:  next_state = ST_TBL_DATA;
      ST_TBL_DATA: next_state = ST_IDLE;
    endcase
  end

  assign o_ready = (state == ST_IDLE);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Architectural state

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_work_register <= WORK_RST;
    end else if (work_load) begin
      o_work_register <= work_value;
    end
  end

  // Swaps, skips and table reads leave the flag alone
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_zero_flag <= ZERO_RST;
    end else if (accept && is_xor_op) begin
      o_zero_flag <= xor_zero;                                      // see RQ14
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_table_high_byte_latch <= LATCH_RST[HI_W-1:0];
    end else if (state == ST_TBL_DATA) begin
      o_table_high_byte_latch <= prog_hi;                           // see RQ8 RQ9 RQ10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory ports

  // Target address is held so a table write lands on the byte named at issue
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      table_addr_hold <= ZERO_BYTE;
    end else if (accept) begin
      table_addr_hold <= i_addr;
    end
  end

  assign mem_target = (state == ST_TBL_DATA) ? table_addr_hold : i_addr;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mem_we    <= 1'b0;
      o_mem_addr  <= ZERO_BYTE;
      o_mem_wdata <= ZERO_BYTE;
    end else begin
      o_mem_we    <= mem_write_now || (state == ST_TBL_DATA);       // see RQ1 RQ12
      o_mem_addr  <= mem_target;
      o_mem_wdata <= (state == ST_TBL_DATA) ? prog_lo : mem_wdata_now;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prog_re   <= 1'b0;
      o_prog_addr <= '0;
    end else begin
      o_prog_re <= accept && is_table_op;
      if (accept && is_table_op) begin
        o_prog_addr <= table_addr;                                  // see RQ8 RQ9 RQ10
      end
    end
  end

  // Pulse marks the dummy cycle; the fetch path drops the fetched word
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_skip <= 1'b0;
    end else begin
      o_skip <= skip_taken;                                         // see RQ3 RQ4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  swap_mem_write_a: assert property ( // see RQ1
    accept && is_swap_mem |=> o_mem_we && o_mem_wdata == $past(swapped)
      && $stable(o_zero_flag) && $stable(o_work_register))
    else $error("memory nibble exchange wrong");

  swap_work_load_a: assert property ( // see RQ2
    accept && is_swap_work |=> o_work_register == $past(swapped) && !o_mem_we
      && $stable(o_zero_flag))
    else $error("work register nibble exchange wrong");

  zero_skip_taken_a: assert property ( // see RQ3
    accept && is_skip_zero && byte_zero |=> o_skip && !o_ready ##1 o_ready && !o_skip)
    else $error("zero skip not taken");

  skip_two_cycle_a: assert property ( // see RQ4
    skip_taken |=> (state == ST_SKIP) ##1 (state == ST_IDLE))
    else $error("taken skip not two cycles");

  skip_not_taken_a: assert property ( // see RQ5
    accept && is_skip_op && !skip_cond |=> !o_skip && o_ready)
    else $error("untaken skip stalled");

  copy_skip_load_a: assert property ( // see RQ6
    accept && is_copy_skip |=> o_work_register == $past(i_mem_rdata)
      && o_skip == $past(byte_zero) && $stable(o_zero_flag))
    else $error("copy and skip wrong");

  bit_skip_test_a: assert property ( // see RQ7
    accept && is_skip_bit |=> o_skip == !$past(sel_bit))
    else $error("bit skip wrong");

  table_read_seq_a: assert property ( // see RQ8
    accept && is_table_op |=> o_prog_re && o_prog_addr == $past(table_addr)
      ##2 o_mem_we && o_mem_wdata == $past(prog_lo)
      && o_table_high_byte_latch == $past(prog_hi))
    else $error("table read sequence wrong");

  cur_page_addr_a: assert property ( // see RQ9
    accept && is_tbl_cur |=> o_prog_addr[PC_WIDTH-1:PTR_W] == $past(i_pc[PC_WIDTH-1:PTR_W]))
    else $error("current page address wrong");

  last_page_addr_a: assert property ( // see RQ10
    accept && is_tbl_last |=> &o_prog_addr[PC_WIDTH-1:PTR_W])
    else $error("last page address wrong");

  xor_work_res_a: assert property ( // see RQ11
    accept && (is_xor_work || is_xor_imm) |=> o_work_register == $past(xor_res) && !o_mem_we)
    else $error("work exclusive-or wrong");

  xor_mem_write_a: assert property ( // see RQ12
    accept && is_xor_mem |=> o_mem_we && o_mem_wdata == $past(xor_res)
      && $stable(o_work_register))
    else $error("memory exclusive-or wrong");

  xor_imm_operand_a: assert property ( // see RQ13
    accept && is_xor_imm |=> o_work_register == ($past(o_work_register) ^ $past(i_imm)))
    else $error("immediate exclusive-or wrong");

  zero_flag_xor_a: assert property ( // see RQ14
    accept && is_xor_op |=> o_zero_flag == $past(xor_zero))
    else $error("zero flag wrong");

  zero_flag_hold_a: assert property ( // see RQ14
    !(accept && is_xor_op) |=> $stable(o_zero_flag))
    else $error("zero flag changed by other op");

endmodule

// *** shared/exec_pkg.sv ***
// Shared constants and types for the closing instruction execution unit
package exec_pkg;

  localparam int DATA_W   = 8;
  localparam int NIB_W    = 4;
  localparam int WORD_W   = 16;
  localparam int PC_W     = 13;
  localparam int PTR_W    = 8;
  localparam int BIT_W    = 3;

  localparam logic [DATA_W-1:0] WORK_RST  = 8'h00;
  localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
  localparam logic              ZERO_RST  = 1'b0;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_SWAP_MEM  = 4'h1,
    OP_SWAP_WORK = 4'h2,
    OP_SKIP_ZERO = 4'h3,
    OP_COPY_SKIP = 4'h4,
    OP_SKIP_BIT  = 4'h5,
    OP_TBL_SPEC  = 4'h6,
    OP_TBL_CUR   = 4'h7,
    OP_TBL_LAST  = 4'h8,
    OP_XOR_WORK  = 4'h9,
    OP_XOR_MEM   = 4'ha,
    OP_XOR_IMM   = 4'hb
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_SKIP     = 2'b01,
    ST_TBL_REQ  = 2'b10,
    ST_TBL_DATA = 2'b11
  } state_t;

endpackage

// *** tb/mem_model.sv ***
// Behavioural program flash and data memory facing the execution unit
`timescale 1ns/10ps

module mem_model #(
  parameter int PC_WIDTH = 13
) (
  input  wire logic                i_clk,
  input  wire logic                i_mem_we,
  input  wire logic [7:0]          i_mem_addr,
  input  wire logic [7:0]          i_mem_wdata,
  input  wire logic [7:0]          i_rd_addr,
  output logic      [7:0]          o_mem_rdata,
  input  wire logic                i_prog_re,
  input  wire logic [PC_WIDTH-1:0] i_prog_addr,
  output logic      [15:0]         o_prog_rdata
);
  logic [7:0] data [256];

  assign o_mem_rdata = data[i_rd_addr];

  initial o_prog_rdata = 16'h0000;

  always @(posedge i_clk) begin
    if (i_mem_we) begin
      data[i_mem_addr] <= i_mem_wdata;
    end
    // Word toggles outside its slot so a late capture never looks fresh
    if (i_prog_re) begin
      o_prog_rdata <= 16'(i_prog_addr) ^ 16'ha55a;
    end else begin
      o_prog_rdata <= ~o_prog_rdata;
    end
  end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the nibble, skip, table and exclusive-or execution unit
`timescale 1ns/10ps

module tb;
  import exec_pkg::*;

  logic        i_clk, i_rstn, i_valid;
  op_t         i_op;
  logic [7:0]  i_addr, i_imm, i_mem_rdata, i_table_low_pointer, i_table_high_pointer;
  logic [2:0]  i_bit;
  logic [12:0] i_pc, o_prog_addr;
  logic [15:0] i_prog_rdata;
  logic        o_ready, o_skip, o_mem_we, o_prog_re, o_zero_flag;
  logic [7:0]  o_mem_addr, o_mem_wdata, o_work_register, o_table_high_byte_latch;
  int          err_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  nibble_skip_table_xor_exec uut (.i_clk, .i_rstn, .i_valid, .i_op, .i_addr, .i_bit, .i_imm,
    .i_mem_rdata, .i_pc, .i_table_low_pointer, .i_table_high_pointer, .i_prog_rdata,
    .o_ready, .o_skip, .o_mem_we, .o_mem_addr, .o_mem_wdata, .o_prog_re, .o_prog_addr,
    .o_work_register, .o_zero_flag, .o_table_high_byte_latch);

  mem_model model (.i_clk, .i_mem_we(o_mem_we), .i_mem_addr(o_mem_addr),
    .i_mem_wdata(o_mem_wdata), .i_rd_addr(i_addr), .o_mem_rdata(i_mem_rdata),
    .i_prog_re(o_prog_re), .i_prog_addr(o_prog_addr), .o_prog_rdata(i_prog_rdata));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Run is about 55 cycles; the ceiling only catches a stuck handshake
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Presets the operand byte and returns one step into cycle 1
  task automatic exec(input op_t op, input logic [7:0] a, input logic [7:0] pre,
                      input logic [2:0] b, input logic [7:0] imm);
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_op <= op;
    i_addr <= a;
    i_bit <= b;
    i_imm <= imm;
    model.data[a] <= pre;
    @(posedge i_clk);
    i_valid <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_swap_xor();
    exec(OP_XOR_IMM, 8'h00, 8'h00, 3'd0, 8'ha5);
    check(o_work_register, 8'ha5);
    exec(OP_XOR_IMM, 8'h00, 8'h00, 3'd0, 8'ha5);
    check(o_work_register, 8'h00);
    check(o_zero_flag, 1'b1);
    exec(OP_SWAP_MEM, 8'h10, 8'h3c, 3'd0, 8'h00);
    check({o_mem_we, o_mem_addr, o_mem_wdata}, {1'b1, 8'h10, 8'hc3});
    check({o_zero_flag, o_work_register}, {1'b1, 8'h00});
    exec(OP_SWAP_WORK, 8'h11, 8'h5a, 3'd0, 8'h00);
    check({o_mem_we, o_work_register, o_zero_flag}, {1'b0, 8'ha5, 1'b1});
    exec(OP_XOR_WORK, 8'h12, 8'h81, 3'd0, 8'h00);
    check({o_mem_we, o_work_register, o_zero_flag}, {1'b0, 8'h24, 1'b0});
    exec(OP_XOR_MEM, 8'h13, 8'h24, 3'd0, 8'h00);
    check({o_mem_we, o_mem_addr, o_mem_wdata}, {1'b1, 8'h13, 8'h00});
    check({o_work_register, o_zero_flag}, {8'h24, 1'b1});
    @(posedge i_clk);
    #1;
    check({model.data[8'h10], model.data[8'h11]}, {8'hc3, 8'h5a});
    check(model.data[8'h13], 8'h00);
  endtask

  task automatic test_skips();
    op_t        ops [6] = '{OP_SKIP_ZERO, OP_SKIP_ZERO, OP_COPY_SKIP, OP_COPY_SKIP,
                            OP_SKIP_BIT, OP_SKIP_BIT};
    logic [7:0] val [6] = '{8'h00, 8'h80, 8'h00, 8'h07, 8'hfb, 8'hfb};
    logic [2:0] sel [6] = '{3'd0, 3'd0, 3'd0, 3'd0, 3'd2, 3'd3};
    logic       tak [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0] work;
    work = 8'h24;
    for (int k = 0; k < 6; k++) begin
      if (ops[k] == OP_COPY_SKIP) begin
        work = val[k];
      end
      exec(ops[k], 8'h20, val[k], sel[k], 8'h00);
      check(o_skip, tak[k]);
      check(o_ready, !tak[k]);
      check({o_work_register, o_zero_flag}, {work, 1'b1});
      @(posedge i_clk);
      #1;
      check({o_skip, o_ready}, 2'b01);
    end
  endtask

  task automatic test_tables();
    op_t         ops [3] = '{OP_TBL_SPEC, OP_TBL_CUR, OP_TBL_LAST};
    logic [12:0] pa  [3] = '{13'h1234, 13'h0b34, 13'h1f34};
    logic [15:0] w;
    for (int k = 0; k < 3; k++) begin
      w = {3'b000, pa[k]} ^ 16'ha55a;
      exec(ops[k], 8'(8'h30 + k), 8'hee, 3'd0, 8'h00);
      check({o_prog_re, o_ready}, 2'b10);
      check(o_prog_addr, pa[k]);
      repeat (2) begin
        @(posedge i_clk);
        #1;
      end
      check({o_mem_we, o_ready, o_mem_addr}, {2'b11, 8'(8'h30 + k)});
      check({o_table_high_byte_latch, o_mem_wdata}, w);
    end
  endtask

  // Request held into the dummy cycle must be refused; an empty op changes nothing
  task automatic test_refused();
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_op <= OP_SKIP_ZERO;
    i_addr <= 8'h40;
    model.data[8'h40] <= 8'h00;
    @(posedge i_clk);
    i_op <= OP_XOR_IMM;
    i_imm <= 8'hff;
    @(posedge i_clk);
    i_valid <= 1'b0;
    #1;
    check({o_skip, o_ready, o_work_register, o_zero_flag}, {2'b01, 8'h07, 1'b1});
    exec(OP_NOP, 8'h41, 8'h00, 3'd0, 8'hff);
    check({o_skip, o_mem_we, o_prog_re, o_ready, o_work_register, o_zero_flag},
          {4'b0001, 8'h07, 1'b1});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rstn = 1'b0;
    i_valid = 1'b0;
    i_op = OP_NOP;
    i_addr = 8'h00;
    i_bit = 3'd0;
    i_imm = 8'h00;
    i_pc = 13'h0b77;
    i_table_low_pointer = 8'h34;
    i_table_high_pointer = 8'h12;
    repeat (5) @(posedge i_clk);
    #1;
    check({o_ready, o_skip, o_mem_we, o_prog_re}, 4'b1000);
    check({o_work_register, o_table_high_byte_latch}, {WORK_RST, LATCH_RST});
    @(posedge i_clk);
    i_rstn <= 1'b1;
    test_swap_xor();
    test_skips();
    test_tables();
    test_refused();
    end_of_test();
  end
endmodule
